// File: bench/mic_core_model.sv
`timescale 1ns/1ns
module mic_core_model (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // controller side
  input wire logic        pc_load,
  input wire logic [12:0] pc_value,
  input wire logic        wake_req,
  input wire logic        phase_q1,
  output logic     [12:0] core_pc,
  output logic            core_asleep,
  output logic            ret_q,
  // bench commands
  input wire logic        sleep_cmd,
  input wire logic        ret_cmd
);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_pc     <= 13'h0000;
      core_asleep <= 1'b0;
      ret_q       <= 1'b0;
    end
    else
    begin
      ret_q <= ret_cmd;
      if (pc_load)
        core_pc <= pc_value;
      else if (phase_q1 && !core_asleep)
        core_pc <= core_pc + 13'h0001;
      if (wake_req)
        core_asleep <= 1'b0;
      else if (sleep_cmd)
        core_asleep <= 1'b1;
    end
  end
endmodule // mic_core_model

// File: bench/mic_irq_chk_properties.sv
`timescale 1ns/1ns
module mic_irq_chk #(
  parameter PC_W = 13
) (
  // apb
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // core side
  input wire logic            core_asleep,
  input wire logic            irq_take,
  input wire logic            wake_req,
  input wire logic            pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic            stack_push,
  input wire logic            phase_q1
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // one instruction cycle is four phase clocks
  sequence q1_gap_s;
    !phase_q1 [*3] ##1 phase_q1;
  endsequence
  sequence vec_load_s;
    pc_load && pc_value == 13'h0004;
  endsequence

  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  irq_vector_a: assert property (irq_take |-> ##[0:12] vec_load_s)
    else $error("no vector load after take");
  irq_push_a: assert property (irq_take |-> ##[0:12] stack_push)
    else $error("no return push after take");
  q1_period_a: assert property (phase_q1 |=> q1_gap_s)
    else $error("phase marker period wrong");
  reset_pc_a: assert property ($rose(presetn) |-> pc_load && pc_value == 0)
    else $error("pc not zero after reset");
  wake_asleep_a: assert property (wake_req |-> $past(core_asleep))
    else $error("wake while awake");
  wake_once_a: assert property (wake_req |=> !wake_req)
    else $error("wake repeated");
endmodule // mic_irq_chk

bind mic_irq_ctrl mic_irq_chk #(.PC_W(PC_W)) u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .core_asleep, .irq_take,
  .wake_req, .pc_load, .pc_value, .stack_push, .phase_q1);

// File: bench/mic_irq_ctrl_tb.sv
`timescale 1ns/1ns
module mic_irq_ctrl_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, external_irq_pin = 0, wrap = 0;
  logic        bo = 0, wd = 0, sleep_cmd = 0, ret_cmd = 0, ret;
  logic        prd = 0, wdw = 0;
  logic [5:0]  pa = 6'h00;
  logic [12:0] stack_data, wake_pc = 13'h0000, pc_prev = 13'h0000;
  logic [7:0]  pev = 8'h00, r8;
  logic [12:0] core_pc, pc_value;
  logic        core_asleep, irq_take, wake_req, pc_load, stack_push, phase_q1;
  int          n_fail = 0, check_count = 0, cyc = 0, n0;
  int          n_irq = 0, n_wake = 0, n_rst = 0;
  logic [33:0] notes[$];
  logic [31:0] seed = 32'h0000C0B7;

  always #4 pclk = ~pclk;

  mic_irq_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .external_irq_pin,
    .port_a_pins(pa), .port_read(prd), .core_timer_wrap(wrap),
    .periph_events(pev), .core_pc, .core_asleep,
    .return_from_irq_instruction(ret), .brownout_evt(bo), .watchdog_evt(wd),
    .watchdog_wake(wdw), .irq_take, .wake_req, .pc_load, .pc_value,
    .stack_push, .stack_data, .phase_q1);

  mic_core_model u_core (.pclk, .presetn, .pc_load, .pc_value, .wake_req,
    .phase_q1, .core_pc, .core_asleep, .ret_q(ret), .sleep_cmd, .ret_cmd);

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task final_report();
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // note holds {is_read, err, data}
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [33:0] e);
    notes.push_back(e);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {2'b00, 32'h0});
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {2'b10, e});
  endtask

  task pin(input logic v);
    @(posedge pclk);
    external_irq_pin <= v;
    repeat (24) @(posedge pclk);
  endtask

  task nap();
    @(posedge pclk);
    sleep_cmd <= 1;
    @(posedge pclk);
    sleep_cmd <= 0;
  endtask

  always @(posedge pclk)
  begin : watch
    logic [33:0] e;
    cyc++;
    if (irq_take === 1'b1) n_irq++;
    if (wake_req === 1'b1) n_wake++;
    if (wake_req === 1'b1) wake_pc = pc_value;
    if (irq_take === 1'b1)
      chk("vector", {pc_load, pc_value}, {1'b1, 13'h0004});
    if (stack_push === 1'b1)
      chk("stack data", stack_data, pc_prev);
    pc_prev = core_pc;
    if (pc_load === 1'b1 && pc_value === 13'h0000) n_rst++;
    if (psel && penable && pready === 1'b1 && notes.size() > 0)
    begin
      e = notes.pop_front();
      chk("pslverr", pslverr, e[32]);
      if (e[33]) chk("prdata", prdata, e[31:0]);
    end
    if (cyc > 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 32'h00);
    rd(12'h004, 32'h00);
    rd(12'h008, 32'h00);
    rd(12'h010, 32'h03);
    rd(12'h014, 32'h01);
    rd(12'h018, 32'h00);
    apb(1'b0, 12'h01C, 32'h0, {2'b11, 32'h0});
    r = xs();
    r8 = r[7:0] | 8'h01;
    wr(12'h004, {24'h0, r8});
    rd(12'h004, {24'h0, r8});
    @(posedge pclk);
    wrap <= 1; pev <= r8;
    @(posedge pclk);
    wrap <= 0; pev <= 8'h00;
    repeat (4) @(posedge pclk);
    rd(12'h000, 32'h04);
    rd(12'h008, {24'h0, r8});
    wr(12'h000, 32'h80);
    repeat (30) @(posedge pclk);
    chk("irq count", n_irq, 0);
    wr(12'h000, 32'hC0);
    repeat (30) @(posedge pclk);
    chk("irq count", n_irq, 1);
    rd(12'h000, 32'h40);
    @(posedge pclk);
    ret_cmd <= 1;
    @(posedge pclk);
    ret_cmd <= 0;
    repeat (30) @(posedge pclk);
    chk("irq count", n_irq, 2);
    wr(12'h008, 32'h00);
    wr(12'h000, 32'h90);
    pin(1'b1);
    chk("irq count", n_irq, 3);
    rd(12'h000, 32'h12);
    wr(12'h000, 32'h10);
    pin(1'b0);
    rd(12'h000, 32'h10);
    wr(12'h014, 32'h00);
    pin(1'b1);
    pin(1'b0);
    rd(12'h000, 32'h12);
    wr(12'h000, 32'h10);
    @(posedge pclk);
    sleep_cmd <= 1;
    @(posedge pclk);
    sleep_cmd <= 0;
    pin(1'b1);
    pin(1'b0);
    chk("wake count", n_wake, 1);
    chk("irq count", n_irq, 3);
    chk("asleep", core_asleep, 0);
    rd(12'h018, 32'h08);
    wr(12'h000, 32'h90);
    nap();
    pin(1'b1);
    n0 = core_pc;
    pin(1'b0);
    chk("wake count", n_wake, 2);
    chk("wake pc", wake_pc, n0 + 1);
    chk("irq count", n_irq, 4);
    wr(12'h000, 32'h08);
    wr(12'h00C, 32'h04);
    rd(12'h00C, 32'h04);
    pa <= 6'h3B;
    repeat (8) @(posedge pclk);
    rd(12'h000, 32'h08);
    prd <= 1;
    pa <= 6'h3F;
    repeat (8) @(posedge pclk);
    prd <= 0;
    rd(12'h000, 32'h09);
    rd(12'h018, 32'h08);
    wr(12'h000, 32'h00);
    nap();
    repeat (4) @(posedge pclk);
    n0 = core_pc;
    wdw <= 1;
    @(posedge pclk);
    wdw <= 0;
    repeat (4) @(posedge pclk);
    chk("wake count", n_wake, 3);
    chk("wake pc", wake_pc, n0 + 1);
    n0 = n_rst;
    @(posedge pclk);
    bo <= 1;
    @(posedge pclk);
    bo <= 0;
    rd(12'h010, 32'h02);
    chk("pc reset", n_rst > n0, 1);
    n0 = n_rst;
    @(posedge pclk);
    wd <= 1;
    @(posedge pclk);
    wd <= 0;
    rd(12'h010, 32'h02);
    chk("pc reset", n_rst > n0, 1);
    final_report();
  end
endmodule // mic_irq_ctrl_tb

// File: verilog/mic_irq_ctrl.v
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "mic_map.vh"
module mic_irq_ctrl #(
  parameter PORT_W = 6,
  parameter PC_W   = 13
) (
  // apb
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  // event sources
  input  wire              external_irq_pin,
  input  wire [PORT_W-1:0] port_a_pins,
  input  wire              port_read,
  input  wire              core_timer_wrap,
  input  wire [7:0]        periph_events,
  // core sequencer
  input  wire [PC_W-1:0]   core_pc,
  input  wire              core_asleep,
  input  wire              return_from_irq_instruction,
  input  wire              brownout_evt,
  input  wire              watchdog_evt,
  input  wire              watchdog_wake,
  output reg               irq_take,
  output reg               wake_req,
  output reg               pc_load,
  output reg  [PC_W-1:0]   pc_value,
  output reg               stack_push,
  output reg  [PC_W-1:0]   stack_data,
  output reg               phase_q1
);
  localparam [1:0] PH_Q1 = 2'h0;
  localparam [1:0] PH_Q2 = 2'h1;
  localparam [1:0] PH_Q4 = 2'h3;
  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_WAKE = 2'h2;
  localparam PH_CYC = (`MIC_PH_CYC < 1) ? 1 : `MIC_PH_CYC;

  reg  [7:0]        intctl_q;
  reg  [7:0]        pie_q;
  reg  [7:0]        pir_q;
  reg  [PORT_W-1:0] pchen_q;
  reg  [7:0]        pwr_q;
  reg  [7:0]        corectl_q;
  reg  [2:0]        pin_s_q;
  reg  [PORT_W-1:0] pa_s1_q;
  reg  [PORT_W-1:0] pa_s2_q;
  reg  [PORT_W-1:0] pa_s3_q;
  reg  [PORT_W-1:0] pa_latch_q;
  reg  [7:0]        ph_cnt_q;
  reg  [1:0]        phase_q;
  reg  [1:0]        state_q;
  reg  [1:0]        lat_q;
  reg               gie_drop_q;
  reg               pin_hold_q;

  // apb access strobes
  wire acc = psel & penable;
  wire wr  = acc & pwrite;

  function hit;
    input [11:0] a;
    input [11:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  wire ph_tick = (ph_cnt_q == PH_CYC[7:0] - 8'h01);
  wire q1_edge = ph_tick & (phase_q == PH_Q4);
  wire in_q4q1 = (phase_q == PH_Q4) | (phase_q == PH_Q1);

  // pin edge from the 2nd/3rd synchroniser stages
  wire pin_rise = pin_s_q[1] & ~pin_s_q[2];
  wire pin_fall = ~pin_s_q[1] & pin_s_q[2];
  wire pin_edge = corectl_q[`MIC_B_EDGE] ? pin_rise : pin_fall;
  // edges seen in Q2/Q3 wait in pin_hold_q so none is lost
  wire pin_set  = (pin_edge | pin_hold_q) & in_q4q1;
  wire pa_agree = (pa_s2_q == pa_s3_q);
  // a change while the port is being read in Q2 is held off until Q3
  wire pa_miss  = port_read & (phase_q == PH_Q2);
  wire pa_chg   = pa_agree & |((pa_s2_q ^ pa_latch_q) & pchen_q)
                  & ~pa_miss;

  // enabled core flags, then enabled peripheral flags behind the group gate
  wire core_pend = (intctl_q[`MIC_B_TIE]  & intctl_q[`MIC_B_TIF])
                 | (intctl_q[`MIC_B_PINE] & intctl_q[`MIC_B_PINF])
                 | (intctl_q[`MIC_B_PCIE] & intctl_q[`MIC_B_PCF]);
  wire per_pend  = intctl_q[`MIC_B_PERIPH_GROUP_ENABLE] & |(pie_q & pir_q);
  wire any_pend  = core_pend | per_pend;
  wire global_irq_enable       = intctl_q[`MIC_B_GIE];
  // software write that drops the global enable
  wire gie_wr0   = wr & hit(paddr, `MIC_ADDR_INTCTL)
                   & ~pwdata[`MIC_B_GIE];
  // one wake per sleep: the core only drops core_asleep an edge after
  // wake_req, so the pulse itself blocks a second wake
  wire wake_ok   = core_asleep & ~wake_req;

  // phase sequencer
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_cnt_q <= 8'h00;
      phase_q  <= PH_Q1;
    end
    else if (ph_tick)
    begin
      ph_cnt_q <= 8'h00;
      phase_q  <= phase_q + 2'h1;
    end
    else
      ph_cnt_q <= ph_cnt_q + 8'h01;
  end

  // input synchronisers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s_q    <= 3'h0;
      pa_s1_q    <= {PORT_W{1'b0}};
      pa_s2_q    <= {PORT_W{1'b0}};
      pa_s3_q    <= {PORT_W{1'b0}};
      pa_latch_q <= {PORT_W{1'b0}};
    end
    else
    begin
      pin_s_q <= {pin_s_q[1:0], external_irq_pin};
      pa_s1_q <= port_a_pins;
      pa_s2_q <= pa_s1_q;
      pa_s3_q <= pa_s2_q;
      if (pa_agree & ~pa_miss)
        pa_latch_q <= pa_s2_q;
    end
  end

  // registers; hardware set beats software clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      intctl_q  <= `MIC_RST_INTCTL;
      pie_q     <= `MIC_RST_PIE;
      pir_q     <= `MIC_RST_PIR;
      pchen_q   <= `MIC_RST_PCHEN;
      corectl_q <= `MIC_RST_CORECTL;
    end
    else
    begin
      if (wr & hit(paddr, `MIC_ADDR_INTCTL))
        intctl_q <= pwdata[7:0];
      if (wr & hit(paddr, `MIC_ADDR_PIE))
        pie_q <= pwdata[7:0];
      if (wr & hit(paddr, `MIC_ADDR_PCHEN))
        pchen_q <= pwdata[PORT_W-1:0];
      if (wr & hit(paddr, `MIC_ADDR_CORECTL))
        corectl_q <= pwdata[7:0];
      pir_q <= ((wr & hit(paddr, `MIC_ADDR_PIR)) ? pwdata[7:0] : pir_q)
               | periph_events;
      if (core_timer_wrap)
        intctl_q[`MIC_B_TIF] <= 1'b1;
      if (pin_set)
        intctl_q[`MIC_B_PINF] <= 1'b1;
      if (pa_chg)
        intctl_q[`MIC_B_PCF] <= 1'b1;
      if (watchdog_evt | brownout_evt)
        intctl_q[`MIC_B_GIE] <= 1'b0;
      else if (irq_take)
        intctl_q[`MIC_B_GIE] <= 1'b0;
      else if (return_from_irq_instruction)
        intctl_q[`MIC_B_GIE] <= 1'b1;
    end
  end

  // power status: presetn is power-up only; watchdog and other resets
  // leave it alone, brown-out clears bit 0
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwr_q <= `MIC_RST_PWR;
    else if (brownout_evt)
      pwr_q <= pwr_q & ~8'h01;
    else if (wr & hit(paddr, `MIC_ADDR_PWRSTAT))
      pwr_q <= pwdata[7:0];
  end

  // hold a pin edge that lands in Q2/Q3 until the flag window opens
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_hold_q <= 1'b0;
    else
      pin_hold_q <= (pin_hold_q | pin_edge) & ~in_q4q1;
  end

  // service sequencer, latency counted in Q1 boundaries
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= ST_RUN;
      lat_q      <= 2'h0;
      gie_drop_q <= 1'b0;
      irq_take   <= 1'b0;
      wake_req   <= 1'b0;
      pc_load    <= 1'b1;
      pc_value   <= `MIC_VEC_RST;
      stack_push <= 1'b0;
      stack_data <= {PC_W{1'b0}};
      phase_q1   <= 1'b0;
    end
    else
    begin
      irq_take   <= 1'b0;
      pc_load    <= 1'b0;
      stack_push <= 1'b0;
      wake_req   <= 1'b0;
      phase_q1   <= q1_edge;
      gie_drop_q <= gie_wr0;
      if (watchdog_evt | brownout_evt)
      begin
        state_q  <= ST_RUN;
        pc_load  <= 1'b1;
        pc_value <= `MIC_VEC_RST;
      end
      else
        case (state_q)
          ST_RUN:
          begin
            if (wake_ok & any_pend)
            begin
              wake_req <= 1'b1;
              pc_load  <= 1'b1;
              pc_value <= core_pc + 1'b1;
              state_q  <= global_irq_enable ? ST_WAKE : ST_RUN;
            end
            // watchdog wake continues at the next instruction too
            else if (wake_ok & watchdog_wake)
            begin
              wake_req <= 1'b1;
              pc_load  <= 1'b1;
              pc_value <= core_pc + 1'b1;
            end
            else if (global_irq_enable & any_pend & ~gie_wr0 & ~gie_drop_q & q1_edge)
            begin
              lat_q   <= 2'h1;
              state_q <= ST_WAIT;
            end
          end
          ST_WAIT:
          begin
            if (~global_irq_enable | gie_wr0)
              state_q <= ST_RUN;
            else if (q1_edge)
            begin
              if (lat_q == `MIC_LAT_TCY - 1)
              begin
                irq_take   <= 1'b1;
                stack_push <= 1'b1;
                stack_data <= core_pc;
                pc_load    <= 1'b1;
                pc_value   <= `MIC_VEC_IRQ;
                state_q    <= ST_RUN;
              end
              lat_q <= lat_q + 2'h1;
            end
          end
          ST_WAKE:
          begin
            // one instruction after the wake runs before the vector
            if (q1_edge)
            begin
              lat_q   <= 2'h1;
              state_q <= ST_WAIT;
            end
          end
          default: state_q <= ST_RUN;
        endcase
    end
  end

  // apb read side, zero wait states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable)
      begin
        prdata <= 32'h00000000;
        case (paddr)
          `MIC_ADDR_INTCTL:   prdata[7:0] <= intctl_q;
          `MIC_ADDR_PIE:      prdata[7:0] <= pie_q;
          `MIC_ADDR_PIR:      prdata[7:0] <= pir_q;
          `MIC_ADDR_PCHEN:    prdata[PORT_W-1:0] <= pchen_q;
          `MIC_ADDR_PWRSTAT:  prdata[7:0] <= pwr_q;
          `MIC_ADDR_CORECTL:  prdata[7:0] <= corectl_q;
          `MIC_ADDR_CORESTAT: prdata[3:0] <= {any_pend, global_irq_enable, state_q};
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule // mic_irq_ctrl

// File: verilog/mic_map.vh
`ifndef MIC_MAP_VH
`define MIC_MAP_VH
// register byte addresses on the apb bus
`define MIC_ADDR_INTCTL    12'h000
`define MIC_ADDR_PIE       12'h004
`define MIC_ADDR_PIR       12'h008
`define MIC_ADDR_PCHEN     12'h00C
`define MIC_ADDR_PWRSTAT   12'h010
`define MIC_ADDR_CORECTL   12'h014
`define MIC_ADDR_CORESTAT  12'h018
// interrupt control/status bit positions
`define MIC_B_GIE          7
`define MIC_B_PERIPH_GROUP_ENABLE         6
`define MIC_B_TIE          5
`define MIC_B_PINE         4
`define MIC_B_PCIE         3
`define MIC_B_TIF          2
`define MIC_B_PINF         1
`define MIC_B_PCF          0
// core control bits
`define MIC_B_EDGE         0
// reset values
`define MIC_RST_INTCTL     8'h00
`define MIC_RST_PIE        8'h00
`define MIC_RST_PIR        8'h00
`define MIC_RST_PCHEN      6'h00
`define MIC_RST_PWR        8'h03
`define MIC_RST_CORECTL    8'h01
// vectors and timing
`define MIC_VEC_IRQ        13'h0004
`define MIC_VEC_RST        13'h0000
`define MIC_TCY_NS         32
`define MIC_CLK_NS         8
`define MIC_PH_CYC         (`MIC_TCY_NS / 4 / `MIC_CLK_NS)
`define MIC_LAT_TCY        3
`endif
